// file: rtl/epc_mdio_frame.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// management frame engine: decodes write and read frames
module epc_mdio_frame #(
   parameter logic [4:0] PHY_ADDR = 5'h00   // address this phy answers to
) (
   input  wire logic mclk,   // system clock
   input  wire logic srst,   // synchronous reset
   epc_mgmt_if.eng   m       // register bank side
);
   import epc_pkg::*;

   epc_frm_t    st_q;
   logic [4:0]  cnt_q;
   logic [11:0] hdr_q;
   logic [15:0] sh_q;
   logic        rd_q;

   wire  [11:0] hdr_nx = {hdr_q[10:0], m.mdio_bit};

   assign m.reg_addr = hdr_q[4:0];
   assign m.wr_data  = sh_q;

   // ==========================================================
   // frame sequencer, advanced on each rising management clock edge
   always_ff @(posedge mclk) begin
      m.wr_stb <= 1'b0;
      if (srst) begin
         st_q       <= EPC_F_IDLE;
         cnt_q      <= 5'd0;
         hdr_q      <= 12'h000;
         sh_q       <= 16'h0000;
         rd_q       <= 1'b0;
         m.mdio_out <= 1'b0;
         m.mdio_oe  <= 1'b0;
      end else if (m.mdc_rise) begin
         cnt_q <= cnt_q + 5'd1;
         case (st_q)
            // idle line floats high; first zero opens a frame
            EPC_F_IDLE: begin
               if (!m.mdio_bit) begin
                  st_q <= EPC_F_START;
               end
            end
            EPC_F_START: begin
               st_q  <= m.mdio_bit ? EPC_F_HDR : EPC_F_IDLE;
               cnt_q <= 5'd0;
            end
            EPC_F_HDR: begin
               hdr_q <= hdr_nx;
               if (cnt_q == EPC_HDR_BITS - 5'd1) begin
                  cnt_q <= 5'd0;
                  rd_q  <= (hdr_nx[11:10] == EPC_OP_READ);
                  // frames for others are skipped whole so data is not a start
                  if (hdr_nx[9:5] == PHY_ADDR &&
                      (hdr_nx[11:10] == EPC_OP_READ || hdr_nx[11:10] == EPC_OP_WRITE)) begin
                     st_q <= EPC_F_TA;
                  end else begin
                     st_q <= EPC_F_SKIP;
                  end
               end
            end
            EPC_F_TA: begin
               if (cnt_q == 5'd0) begin
                  m.mdio_oe  <= rd_q;
                  m.mdio_out <= 1'b0;
               end else begin
                  cnt_q <= 5'd0;
                  st_q  <= EPC_F_DATA;
                  if (rd_q) begin
                     m.mdio_out <= m.rd_data[15];
                     sh_q       <= {m.rd_data[14:0], 1'b0};
                  end
               end
            end
            EPC_F_DATA: begin
               if (rd_q) begin
                  m.mdio_out <= sh_q[15];
                  sh_q       <= {sh_q[14:0], 1'b0};
               end else begin
                  sh_q <= {sh_q[14:0], m.mdio_bit};
               end
               if (cnt_q == EPC_DATA_BITS - 5'd1) begin
                  m.wr_stb  <= !rd_q;   // RL6
                  m.mdio_oe <= 1'b0;
                  st_q      <= EPC_F_IDLE;
               end
            end
            EPC_F_SKIP: begin
               if (cnt_q == EPC_SKIP_BITS - 5'd1) begin
                  st_q <= EPC_F_IDLE;
               end
            end
            default: st_q <= EPC_F_IDLE;
         endcase
      end
   end
endmodule
`default_nettype wire

// file: rtl/epc_phy_ctrl.sv
// ==========================================================
// Contract
// RL1: defaults alone give a working link
// RL2: register at address 0, resets 0x3100
// RL3: bit 7 selects collision test mode
// RL4: test collision follows transmit start and stop
// RL5: software writes reserved low bits as zero
// RL6: write frame carries the sixteen data bits
// RL7: read frame returns the sixteen register bits
// RL8: management clock from 8-bit divider, default 0x80
// RL9: reset and restart bits self clear
`timescale 1ns/10ps
`default_nettype none
module epc_phy_ctrl #(
   parameter logic [4:0] PHY_ADDR = 5'h00   // management address of this phy
) (
   input  wire logic mclk,                  // system clock, 200 MHz
   input  wire logic srst,                  // synchronous reset, high
   input  wire logic mdc,                   // management clock pin
   input  wire logic mdio_in,               // management data pin level
   output logic      mdio_out,              // management data driven
   output logic      mdio_oe,               // high while driving data
   input  wire logic tx_en,                 // transmit in progress, same clock
   output logic      col,                   // collision indication
   output logic      regs_resetting,        // reset operation in progress
   output logic      loopback_select,       // loop transmit to receive
   output logic      speed_select,          // 1: 100 Mb/s, 0: 10 Mb/s
   output logic      autoneg_enable,        // auto-negotiation on
   output logic      low_power_select,      // low power state
   output logic      isolate,               // data paths isolated
   output logic      autoneg_restart,       // restart in progress
   output logic      duplex_mode,           // 1: full duplex
   output logic      collision_test_enable  // collision test mode
);
   import epc_pkg::*;

   localparam int RST_WAIT  = EPC_RST_CYC + 1;
   localparam int ANEG_WAIT = EPC_ANEG_CYC + 1;

   epc_mgmt_if m ();

   logic [15:0] phy_control_reg_q;
   logic [7:0]  rst_cnt_q;
   logic [7:0]  an_cnt_q;
   logic        mdc_s1_q, mdc_s2_q, mdc_s3_q;
   logic        dio_s1_q, dio_s2_q;
   logic        col_q;

   wire ctrl_wr = m.wr_stb && (m.reg_addr == EPC_CTRL_ADDR);

   // counters are eight bits, so longer or zero self-clear times are refused
   if (EPC_RST_CYC < 1 || EPC_RST_CYC > 255 ||
       EPC_ANEG_CYC < 1 || EPC_ANEG_CYC > 255) begin : g_cnt_chk
      $error("self-clear counts do not fit the counters");
   end

   // ==========================================================
   // pin synchronisers; mdc is slow enough to edge detect here
   always_ff @(posedge mclk) begin
      if (srst) begin
         mdc_s1_q <= 1'b0;
         mdc_s2_q <= 1'b0;
         mdc_s3_q <= 1'b0;
         dio_s1_q <= 1'b1;
         dio_s2_q <= 1'b1;
      end else begin
         mdc_s1_q <= mdc;
         mdc_s2_q <= mdc_s1_q;
         mdc_s3_q <= mdc_s2_q;
         dio_s1_q <= mdio_in;
         dio_s2_q <= dio_s1_q;
      end
   end

   // divided clock is many mclk periods long, so one edge per pulse
   assign m.mdc_rise = mdc_s2_q && !mdc_s3_q;   // RL8
   assign m.mdio_bit = dio_s2_q;

   // reads of other addresses return zeros
   assign m.rd_data = (m.reg_addr == EPC_CTRL_ADDR) ? phy_control_reg_q : EPC_READ_NONE;   // RL7

   epc_mdio_frame #(
      .PHY_ADDR (PHY_ADDR)
   ) u_frame (
      .mclk (mclk),
      .srst (srst),
      .m    (m.eng)
   );

   assign mdio_out = m.mdio_out;
   assign mdio_oe  = m.mdio_oe;

   // ==========================================================
   // control register; a fresh write beats a pending self clear
   always_ff @(posedge mclk) begin
      if (srst) begin
         phy_control_reg_q <= EPC_CTRL_RESET;   // RL1
      end else if (ctrl_wr) begin
         phy_control_reg_q <= m.wr_data;   // RL2
      end else if (phy_control_reg_q[EPC_B_RESET] && rst_cnt_q == 8'd1) begin
         phy_control_reg_q <= EPC_CTRL_RESET;   // RL9
      end else if (phy_control_reg_q[EPC_B_ANEG_RST] && an_cnt_q == 8'd1) begin
         phy_control_reg_q[EPC_B_ANEG_RST] <= 1'b0;   // RL9
      end
   end

   // reset operation timer
   always_ff @(posedge mclk) begin
      if (srst) begin
         rst_cnt_q <= 8'd0;
      end else if (ctrl_wr) begin
         rst_cnt_q <= m.wr_data[EPC_B_RESET] ? 8'(EPC_RST_CYC) : 8'd0;
      end else if (rst_cnt_q != 8'd0) begin
         rst_cnt_q <= rst_cnt_q - 8'd1;
      end
   end

   // auto-negotiation restart timer
   always_ff @(posedge mclk) begin
      if (srst) begin
         an_cnt_q <= 8'd0;
      end else if (ctrl_wr) begin
         an_cnt_q <= m.wr_data[EPC_B_ANEG_RST] ? 8'(EPC_ANEG_CYC) : 8'd0;
      end else if (an_cnt_q != 8'd0) begin
         an_cnt_q <= an_cnt_q - 8'd1;
      end
   end

   // ==========================================================
   // collision test: col tracks transmit only while enabled
   always_ff @(posedge mclk) begin
      if (srst) begin
         col_q <= 1'b0;
      end else begin
         col_q <= phy_control_reg_q[EPC_B_COLTEST] && tx_en;   // RL4
      end
   end

   assign col = col_q;

   // field outputs straight from the register flops
   assign regs_resetting        = phy_control_reg_q[EPC_B_RESET];
   assign loopback_select       = phy_control_reg_q[EPC_B_LOOPBACK];
   assign speed_select          = phy_control_reg_q[EPC_B_SPEED];
   assign autoneg_enable        = phy_control_reg_q[EPC_B_ANEG_EN];
   assign low_power_select      = phy_control_reg_q[EPC_B_LOWPWR];
   assign isolate               = phy_control_reg_q[EPC_B_ISOLATE];
   assign autoneg_restart       = phy_control_reg_q[EPC_B_ANEG_RST];
   assign duplex_mode           = phy_control_reg_q[EPC_B_DUPLEX];
   assign collision_test_enable = phy_control_reg_q[EPC_B_COLTEST];   // RL3

   // ==========================================================
   // checks
   reset_default_a: assert property ( // RL1
      @(posedge mclk) disable iff (srst)
      $fell(srst) |-> phy_control_reg_q == EPC_CTRL_RESET && speed_select && autoneg_enable)
      else $error("control register not at default after reset");

   write_store_a: assert property ( // RL2
      @(posedge mclk) disable iff (srst)
      ctrl_wr && !m.wr_data[EPC_B_RESET] |=> phy_control_reg_q == $past(m.wr_data))
      else $error("write to control register not stored");

   coltest_set_a: assert property ( // RL3
      @(posedge mclk) disable iff (srst)
      ctrl_wr |=> collision_test_enable == $past(m.wr_data[EPC_B_COLTEST]))
      else $error("collision test bit does not follow write");

   col_follow_a: assert property ( // RL4
      @(posedge mclk) disable iff (srst)
      1'b1 |=> col == ($past(tx_en) && $past(collision_test_enable)))
      else $error("collision output does not track transmit");

   write_frame_a: assert property ( // RL6
      @(posedge mclk) disable iff (srst)
      m.wr_stb |-> !m.mdio_oe ##1 !m.wr_stb)
      else $error("write strobe longer than one cycle or during drive");

   read_turn_a: assert property ( // RL7
      @(posedge mclk) disable iff (srst)
      $rose(mdio_oe) |-> !mdio_out)
      else $error("read turnaround bit not driven low");

   reset_clear_a: assert property ( // RL9
      @(posedge mclk) disable iff (srst)
      $rose(regs_resetting) |-> ##[1:RST_WAIT] !regs_resetting)
      else $error("reset bit did not self clear");

   restart_clear_a: assert property ( // RL9
      @(posedge mclk) disable iff (srst)
      $rose(autoneg_restart) |-> ##[1:ANEG_WAIT] !autoneg_restart)
      else $error("restart bit did not self clear");

   mdc_edge_a: assert property ( // RL8
      @(posedge mclk) disable iff (srst)
      m.mdc_rise |=> !m.mdc_rise)
      else $error("management clock edge longer than one cycle");

   rst_write_a: assert property ( // RL9
      @(posedge mclk) disable iff (srst)
      ctrl_wr && m.wr_data[EPC_B_RESET] |=> regs_resetting)
      else $error("reset bit write not stored");

   restart_write_a: assert property ( // RL9
      @(posedge mclk) disable iff (srst)
      ctrl_wr && m.wr_data[EPC_B_ANEG_RST] |=> autoneg_restart)
      else $error("restart bit write not stored");

   reset_restore_a: assert property ( // RL9
      @(posedge mclk) disable iff (srst)
      $fell(regs_resetting) && !$past(ctrl_wr) |-> phy_control_reg_q == EPC_CTRL_RESET)
      else $error("register not at default after reset operation");

   col_idle_a: assert property ( // RL3
      @(posedge mclk) disable iff (srst)
      !collision_test_enable |=> !col)
      else $error("collision raised outside test mode");

   other_addr_a: assert property ( // RL2
      @(posedge mclk) disable iff (srst)
      m.wr_stb && m.reg_addr != EPC_CTRL_ADDR && !regs_resetting
      |=> $stable(phy_control_reg_q[EPC_B_DUPLEX:0]))
      else $error("write to another address changed the register");

   oe_release_a: assert property ( // RL7
      @(posedge mclk) disable iff (srst)
      $fell(mdio_oe) |-> $past(m.mdc_rise) || $past(srst))
      else $error("data drive released outside a clock edge");

   out_stand_a: assert property ( // RL7
      @(posedge mclk) disable iff (srst)
      mdio_oe && !$past(m.mdc_rise) |-> $stable(mdio_out))
      else $error("driven read bit changed between clock edges");
endmodule
`default_nettype wire

// file: shared/epc_mgmt_if.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// link between register bank and management frame engine
interface epc_mgmt_if;
   logic        mdc_rise;   // synchronised management clock edge
   logic        mdio_bit;   // synchronised data level
   logic [15:0] rd_data;    // value returned on a read
   logic        wr_stb;     // one-cycle write strobe
   logic [4:0]  reg_addr;   // register address of frame
   logic [15:0] wr_data;    // data of a write frame
   logic        mdio_out;   // data to drive
   logic        mdio_oe;    // drive enable

   modport ctrl (output mdc_rise, mdio_bit, rd_data,
                 input  wr_stb, reg_addr, wr_data, mdio_out, mdio_oe);
   modport eng  (input  mdc_rise, mdio_bit, rd_data,
                 output wr_stb, reg_addr, wr_data, mdio_out, mdio_oe);
endinterface
`default_nettype wire

// file: shared/epc_pkg.sv
// ==========================================================
// phy control register constants
package epc_pkg;
   // ==========================================================
   // register map and fields
   localparam logic [4:0]  EPC_CTRL_ADDR   = 5'h00;
   localparam logic [15:0] EPC_CTRL_RESET  = 16'h3100;
   localparam int          EPC_B_RESET     = 15;
   localparam int          EPC_B_LOOPBACK  = 14;
   localparam int          EPC_B_SPEED     = 13;
   localparam int          EPC_B_ANEG_EN   = 12;
   localparam int          EPC_B_LOWPWR    = 11;
   localparam int          EPC_B_ISOLATE   = 10;
   localparam int          EPC_B_ANEG_RST  = 9;
   localparam int          EPC_B_DUPLEX    = 8;
   localparam int          EPC_B_COLTEST   = 7;
   localparam logic [15:0] EPC_READ_NONE   = 16'h0000;

   // ==========================================================
   // timing
   localparam int          EPC_CLK_NS      = 5;
   localparam int          EPC_RST_HOLD_NS = 100;
   localparam int          EPC_ANEG_RST_NS = 100;
   localparam int          EPC_RST_CYC     = (EPC_RST_HOLD_NS + EPC_CLK_NS - 1) / EPC_CLK_NS;
   localparam int          EPC_ANEG_CYC    = (EPC_ANEG_RST_NS + EPC_CLK_NS - 1) / EPC_CLK_NS;
   // management clock divider setting the far end starts from
   localparam logic [7:0]  EPC_MDC_DIV_RST = 8'h80;

   // ==========================================================
   // management frame layout
   localparam logic [1:0]  EPC_OP_WRITE    = 2'b01;
   localparam logic [1:0]  EPC_OP_READ     = 2'b10;
   localparam logic [4:0]  EPC_HDR_BITS    = 5'd12;
   localparam logic [4:0]  EPC_TA_BITS     = 5'd2;
   localparam logic [4:0]  EPC_DATA_BITS   = 5'd16;
   localparam logic [4:0]  EPC_SKIP_BITS   = 5'd18;

   typedef enum logic [2:0] {
      EPC_F_IDLE,
      EPC_F_START,
      EPC_F_HDR,
      EPC_F_TA,
      EPC_F_DATA,
      EPC_F_SKIP
   } epc_frm_t;
endpackage

// file: verification/epc_mac_model.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// management master: clock divider, transmit and receive data
module epc_mac_model (
   input  wire logic mclk,     // system clock
   input  wire logic srst,     // synchronous reset
   input  wire logic mdio_in,  // resolved data wire
   output logic      mdc,      // management clock, still outside frames
   output logic      mac_oe,   // high while driving data
   output logic      mac_out   // data driven
);
   import epc_pkg::*;
   logic [7:0]  div_q;             // half period of mdc in mclk cycles
   logic [15:0] mgmt_tx_data_reg;  // value the next write sends
   logic [15:0] mgmt_rx_data_reg;  // value the last read returned
   logic        smp;               // level seen at the last mdc rise

   // idle pins until the first frame
   initial begin
      mdc     = 1'b0;
      mac_oe  = 1'b0;
      mac_out = 1'b1;
   end

   // divider restarts at its default, which is slow on purpose
   always @(posedge mclk) begin
      if (srst) begin
         div_q <= EPC_MDC_DIV_RST;
      end
   end

   // ==========================================================
   // one bit: data changes with mdc low, sampled at the rise
   task automatic bit_xfer(input logic drv, input logic b);
      mac_oe  = drv;
      mac_out = b;
      repeat (div_q) @(posedge mclk);
      #1 mdc = 1'b1;
      smp = mdio_in;
      repeat (div_q) @(posedge mclk);
      #1 mdc = 1'b0;
   endtask

   // whole frame; reserved low bits always sent as zero
   task automatic send(input logic [1:0] op, input logic [4:0] phy,
                       input logic [4:0] ra, input logic [15:0] v);
      logic [13:0] hdr;
      logic        rd;
      hdr = {2'b01, op, phy, ra};
      rd  = (op == EPC_OP_READ);
      mgmt_tx_data_reg = v & 16'hff80;
      bit_xfer(1'b1, 1'b1);
      for (int i = 13; i >= 0; i--) begin
         bit_xfer(1'b1, hdr[i]);
      end
      // turnaround is released on a read
      bit_xfer(!rd, 1'b1);
      bit_xfer(!rd, rd);
      for (int i = 15; i >= 0; i--) begin
         bit_xfer(!rd, mgmt_tx_data_reg[i]);
         if (rd) begin
            mgmt_rx_data_reg[i] = smp;
         end
      end
      mac_oe = 1'b0;
      // one idle edge so the next frame never re-raises the enable at once
      @(posedge mclk);
      #1;
   endtask
endmodule
`default_nettype wire

// file: verification/tb.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// bench for the phy control register
module tb;
   import epc_pkg::*;
   localparam logic [4:0] PHY = 5'h05;  // management address under test
   logic        mclk = 1'b0;
   logic        srst, tx_en, mdc, mdio_in, mdio_out, mdio_oe, col, mac_oe, mac_out;
   wire  [8:0]  outs;                   // control bits 15 down to 7
   int          err_count, total_checks;
   logic [15:0] wv [2] = '{16'h1200, 16'h8000};
   logic [15:0] ev [2] = '{16'h1000, 16'h3100};
   logic [1:0]  bop [4] = '{EPC_OP_WRITE, 2'b00, 2'b11, EPC_OP_WRITE};
   logic [4:0]  bph [4] = '{5'h04, PHY, PHY, PHY};
   logic [4:0]  bra [4] = '{5'h00, 5'h00, 5'h00, 5'h01};

   always #2.5 mclk = ~mclk;
   // mdio has a pull-up, so a released line reads one
   assign mdio_in = mdio_oe ? mdio_out : (mac_oe ? mac_out : 1'b1);

   epc_mac_model mac (.mclk(mclk), .srst(srst), .mdio_in(mdio_in), .mdc(mdc),
                      .mac_oe(mac_oe), .mac_out(mac_out));
   epc_phy_ctrl #(.PHY_ADDR(PHY)) dut (
      .mclk(mclk), .srst(srst), .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out),
      .mdio_oe(mdio_oe), .tx_en(tx_en), .col(col), .regs_resetting(outs[8]),
      .loopback_select(outs[7]), .speed_select(outs[6]), .autoneg_enable(outs[5]),
      .low_power_select(outs[4]), .isolate(outs[3]), .autoneg_restart(outs[2]),
      .duplex_mode(outs[1]), .collision_test_enable(outs[0]));

   // ==========================================================
   // access and comparison tasks
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic outs_chk(input logic [15:0] e);
      check({7'h00, outs}, {7'h00, e[15:7]});
   endtask
   task automatic rd_chk(input logic [4:0] ra, input logic [15:0] e);
      mac.send(EPC_OP_READ, PHY, ra, 16'h0000);
      check(mac.mgmt_rx_data_reg, e);
   endtask
   task automatic wr(input logic [4:0] ra, input logic [15:0] v);
      mac.send(EPC_OP_WRITE, PHY, ra, v);
   endtask
   // the default divider is slow, so it is shortened after the check
   task automatic div_chk;
      check({8'h00, mac.div_q}, {8'h00, EPC_MDC_DIV_RST});
      mac.div_q = 8'd8;
   endtask
   task automatic complete_run;
      $display("checks %0d, errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // watchdog well beyond the seventeen frames of the run
   initial begin
      repeat (40000) @(posedge mclk);
      err_count++;
      complete_run();
   end

   // ==========================================================
   // test sequence
   initial begin
      srst = 1'b1;
      tx_en = 1'b0;
      err_count = 0;
      total_checks = 0;
      repeat (16) @(posedge mclk);
      #1 srst = 1'b0;
      outs_chk(EPC_CTRL_RESET);
      div_chk();
      rd_chk(5'h00, 16'h3100);
      wr(5'h00, 16'h5d80);
      outs_chk(16'h5d80);
      rd_chk(5'h00, 16'h5d80);
      // collision follows transmit one cycle later
      tx_en = 1'b1;
      @(posedge mclk);
      #1 check({15'h0000, col}, 16'h0001);
      tx_en = 1'b0;
      @(posedge mclk);
      #1 check({15'h0000, col}, 16'h0000);
      wr(5'h00, 16'h2000);
      outs_chk(16'h2000);
      tx_en = 1'b1;
      repeat (2) @(posedge mclk);
      #1 check({15'h0000, col}, 16'h0000);
      tx_en = 1'b0;
      // restart and reset bits hold about twenty cycles, then clear
      for (int i = 0; i < 2; i++) begin
         wr(5'h00, wv[i]);
         outs_chk(wv[i]);
         repeat (13) @(posedge mclk);
         #1 outs_chk(wv[i]);
         repeat (4) @(posedge mclk);
         #1 outs_chk(ev[i]);
         rd_chk(5'h00, ev[i]);
      end
      // refused frames and a write to address 1 leave the register alone
      wr(5'h00, 16'h5d80);
      for (int i = 0; i < 4; i++) begin
         mac.send(bop[i], bph[i], bra[i], 16'h0000);
      end
      rd_chk(5'h00, 16'h5d80);
      rd_chk(5'h01, 16'h0000);
      mac.send(EPC_OP_READ, 5'h04, 5'h00, 16'h0000);
      check(mac.mgmt_rx_data_reg, 16'hffff);
      // reset in mid-run restores defaults
      srst = 1'b1;
      repeat (2) @(posedge mclk);
      #1 srst = 1'b0;
      outs_chk(EPC_CTRL_RESET);
      div_chk();
      rd_chk(5'h00, 16'h3100);
      complete_run();
   end
endmodule
`default_nettype wire
